/* File: mfsf_core_model.sv */
// Core-side fault event source for the status flags block.
// Assumes the bench raises go for exactly one clock per event.
`timescale 1ns/1ps
module mfsf_core_model (
	input  wire logic        go,
	input  wire logic [1:0]  kind,
	input  wire logic [31:0] addr,
	input  wire logic [2:0]  lvl,
	output mfsf_pkg::mfsf_core_ev_t ev
);
	// Pulses only with go; idle address is inverted so stale use shows
	always_comb begin
		ev = '0;
		ev.data_addr = go ? addr : ~addr;
		ev.fetch_xn = lvl[2];
		ev.fetch_mpu_deny = lvl[1];
		ev.mpu_enable = lvl[0];
		ev.stack_err = go && kind == 2'h0;
		ev.unstack_err = go && kind == 2'h1;
		ev.data_err = go && kind == 2'h2;
		ev.fetch_issue = go && kind == 2'h3;
	end
endmodule : mfsf_core_model

/* File: mfsf_pkg.sv */
// Package for the memory fault status flags block.
// Assumes a 32-bit classic Wishbone register bus and one 100 MHz clock.
package mfsf_pkg;

	// Register map, byte addresses on the bus
	localparam int          WB_ADR_W     = 8;
	localparam logic [7:0]  OFS_STATUS   = 8'h00;
	localparam logic [7:0]  OFS_FADDR    = 8'h04;

	// Status byte field positions
	localparam int          BIT_ADDR_VAL = 7;
	localparam int          BIT_STACK    = 4;
	localparam int          BIT_UNSTACK  = 3;
	localparam int          BIT_DATA     = 1;
	localparam int          BIT_FETCH    = 0;

	// Implemented bits; 6:5 and 2 stay zero
	localparam logic [7:0]  STATUS_MASK  = 8'h9B;
	localparam logic [7:0]  STATUS_RESET = 8'h00;
	localparam logic [31:0] FADDR_RESET  = 32'h0000_0000;
	localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

	// Fault events reported by the core in one cycle
	typedef struct packed {
		logic        stack_err;
		logic        unstack_err;
		logic        data_err;
		logic [31:0] data_addr;
		logic        fetch_issue;
		logic        fetch_xn;
		logic        fetch_mpu_deny;
		logic        mpu_enable;
	} mfsf_core_ev_t;

	// Handling directions returned to the core
	typedef struct packed {
		logic fault_take;
		logic adjust_sp;
		logic save_frame;
		logic pc_at_fault;
	} mfsf_core_resp_t;

endpackage : mfsf_pkg

/* File: mfsf_status.sv */
// Memory fault status byte, fault address register and Wishbone slave.
// Assumes the core's fault events are synchronous one-cycle pulses.
//
// Notes on behaviour
// - Bit 7 reads one while the fault address register holds a valid address.
// - Every flag stays set until software writes a one to it.
// - Bits 6:5 and 2 are reserved and always read zero.
// - Bit 4 sets when entry stacking hits an access violation.
// - Entry stacking fault: stack pointer still moves, no address captured.
// - Bit 3 sets when return unstacking hits an access violation.
// - Unstacking fault chains: stack untouched, no new frame, no address.
// - Bit 1 sets on a forbidden load or store.
// - Data fault: return PC at faulting instruction, access address captured.
// - Bit 0 sets on a fetch from a non-executable location.
// - Execute-never fetches fault even with protection disabled or absent.
// - Fetch fault: return PC at faulting instruction, address untouched.
// - While bit 7 is set the address register holds the faulting address until a bus write rewrites it.
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

module mfsf_status (
	input  wire logic                         clk,
	input  wire logic                         sys_rst,
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [mfsf_pkg::WB_ADR_W-1:0] wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [31:0]                  wb_dat_i,
	output logic      [31:0]                  wb_dat_o,
	output logic                              wb_ack_o,
	input  mfsf_pkg::mfsf_core_ev_t           core_ev,
	output mfsf_pkg::mfsf_core_resp_t         core_resp,
	output logic      [7:0]                   mem_fault_status_byte,
	output logic      [31:0]                  mem_fault_address_reg
);

	// Set wins over a one-to-clear in the same cycle
	function automatic logic [7:0] mfsf_w1c(
		input logic [7:0] cur,
		input logic [7:0] set,
		input logic [7:0] clr
	);
		mfsf_w1c = set | (cur & ~clr);
	endfunction : mfsf_w1c

	// Byte-lane merge for a plain read/write word
	function automatic logic [31:0] mfsf_merge(
		input logic [31:0] cur,
		input logic [31:0] wdat,
		input logic [3:0]  sel
	);
		logic [31:0] res;
		res = cur;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = wdat[i*8 +: 8];
			end
		end
		mfsf_merge = res;
	endfunction : mfsf_merge

	logic        req;
	logic        wr_status;
	logic        wr_faddr;
	logic        fetch_viol;
	logic [7:0]  set_vec;
	logic [7:0]  clr_vec;
	logic [7:0]  next_status;
	logic [31:0] next_faddr;
	logic        next_ack;
	logic [31:0] next_rdata;
	mfsf_pkg::mfsf_core_resp_t next_resp;

	// New bus request; ack drops for one cycle between requests
	assign req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_status = req && wb_we_i && wb_sel_i[0]
		&& (wb_adr_i == mfsf_pkg::OFS_STATUS);
	assign wr_faddr  = req && wb_we_i
		&& (wb_adr_i == mfsf_pkg::OFS_FADDR);

	// Execute-never wins
	// Protection deny only counts while the unit is enabled
	assign fetch_viol = core_ev.fetch_issue && (core_ev.fetch_xn
		|| (core_ev.mpu_enable && core_ev.fetch_mpu_deny));

	// Event set vector for the status byte
	always_comb begin
		set_vec = 8'h00;
		set_vec[mfsf_pkg::BIT_STACK]    = core_ev.stack_err;
		set_vec[mfsf_pkg::BIT_UNSTACK]  = core_ev.unstack_err;
		set_vec[mfsf_pkg::BIT_DATA]     = core_ev.data_err;
		set_vec[mfsf_pkg::BIT_FETCH]    = fetch_viol;
		// Valid rises with the address capture
		set_vec[mfsf_pkg::BIT_ADDR_VAL] = core_ev.data_err;
	end

	// Only written ones clear; reserved bits never take a one
	assign clr_vec = wr_status
		? (wb_dat_i[7:0] & mfsf_pkg::STATUS_MASK) : 8'h00;

	// Status and address next values
	always_comb begin
		next_status = mfsf_w1c(mem_fault_status_byte, set_vec, clr_vec)
			& mfsf_pkg::STATUS_MASK;
		next_faddr = mem_fault_address_reg;
		if (wr_faddr) begin
			next_faddr = mfsf_merge(mem_fault_address_reg, wb_dat_i,
				wb_sel_i);
		end
		// Address held until the next data fault
		// Software may still rewrite it; the valid bit does not follow
		// Capture the attempted data address; beats a bus write
		// Stacking, unstacking and fetch faults leave it alone
		if (core_ev.data_err) begin
			next_faddr = core_ev.data_addr;
		end
	end

	// Handling directions for the core
	always_comb begin
		next_resp.fault_take  = core_ev.stack_err || core_ev.unstack_err
			|| core_ev.data_err || fetch_viol;
		// Stacking fault still moves the stack pointer
		// Unstacking fault keeps the old frame, no new save
		next_resp.adjust_sp   = !core_ev.unstack_err;
		next_resp.save_frame  = !core_ev.unstack_err;
		// Precise faults point the return PC at the culprit
		next_resp.pc_at_fault = core_ev.data_err || fetch_viol;
	end

	// Read mux and ack; unmapped addresses read zero and still ack
	always_comb begin
		next_ack   = req;
		next_rdata = mfsf_pkg::RDATA_ZERO;
		if (req && !wb_we_i) begin
			if (wb_adr_i == mfsf_pkg::OFS_STATUS) begin
				// Valid bit reported from its own flop
				next_rdata[7:0] = mem_fault_status_byte;
			end else if (wb_adr_i == mfsf_pkg::OFS_FADDR) begin
				next_rdata = mem_fault_address_reg;
			end
		end
	end

	// Register everything; outputs come straight from these flops
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			mem_fault_status_byte <= mfsf_pkg::STATUS_RESET;
			mem_fault_address_reg <= mfsf_pkg::FADDR_RESET;
			wb_ack_o              <= 1'b0;
			wb_dat_o              <= mfsf_pkg::RDATA_ZERO;
			core_resp             <= '0;
		end else begin
			mem_fault_status_byte <= next_status;
			mem_fault_address_reg <= next_faddr;
			wb_ack_o              <= next_ack;
			wb_dat_o              <= next_rdata;
			core_resp             <= next_resp;
		end
	end

	// Checks on the block's own outputs
	// All of them live in the one clock domain, so share the defaults
	// Reset masks them; the first edge after release compares to zeros
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	a_data_captures_addr: assert property (
		core_ev.data_err |=> mem_fault_address_reg == $past(core_ev.data_addr)
			&& mem_fault_status_byte[mfsf_pkg::BIT_ADDR_VAL])
		else $error("data fault did not capture address and valid");

	a_valid_holds_addr: assert property (
		mem_fault_status_byte[mfsf_pkg::BIT_ADDR_VAL] && !core_ev.data_err
			&& !wr_faddr |=> $stable(mem_fault_address_reg))
		else $error("fault address changed while valid");

	a_fetch_no_capture: assert property (
		fetch_viol && !core_ev.data_err && !wr_faddr
			|=> $stable(mem_fault_address_reg))
		else $error("fetch fault wrote the fault address");

	a_xn_always_faults: assert property (
		core_ev.fetch_issue && core_ev.fetch_xn && !core_ev.mpu_enable
			|=> mem_fault_status_byte[mfsf_pkg::BIT_FETCH]
			&& core_resp.pc_at_fault)
		else $error("execute-never fetch did not fault");

	// Disabled unit denies nothing
	// A deny level from a switched-off unit must not raise a fault
	a_deny_needs_enable: assert property (
		core_ev.fetch_issue && !core_ev.fetch_xn && !core_ev.mpu_enable
			&& !core_ev.data_err |=> !core_resp.pc_at_fault)
		else $error("fetch faulted with protection disabled");

	a_stack_flag_set: assert property (
		core_ev.stack_err |=> mem_fault_status_byte[mfsf_pkg::BIT_STACK]
			&& core_resp.adjust_sp == !$past(core_ev.unstack_err))
		else $error("stacking fault flag not set");

	a_stack_no_capture: assert property (
		core_ev.stack_err && !core_ev.unstack_err && !core_ev.data_err
			&& !wr_faddr |=> $stable(mem_fault_address_reg)
			&& core_resp.adjust_sp && core_resp.save_frame)
		else $error("stacking fault captured an address or kept sp");

	a_unstack_chains: assert property (
		core_ev.unstack_err |=> mem_fault_status_byte[mfsf_pkg::BIT_UNSTACK]
			&& core_resp.fault_take && !core_resp.adjust_sp
			&& !core_resp.save_frame)
		else $error("unstacking fault not chained");

	a_unstack_no_capture: assert property (
		core_ev.unstack_err && !core_ev.data_err && !wr_faddr
			|=> $stable(mem_fault_address_reg))
		else $error("unstacking fault wrote the fault address");

	a_data_flag_set: assert property (
		core_ev.data_err |=> mem_fault_status_byte[mfsf_pkg::BIT_DATA]
			&& core_resp.fault_take && core_resp.pc_at_fault)
		else $error("data fault flag not set");

	a_fetch_flag_set: assert property (
		fetch_viol |=> mem_fault_status_byte[mfsf_pkg::BIT_FETCH]
			&& core_resp.fault_take && core_resp.pc_at_fault)
		else $error("fetch fault flag not set");

	// Data flag sticky
	// One cycle ahead only: a clear may legally follow in the next cycle
	a_flags_sticky: assert property (
		mem_fault_status_byte[mfsf_pkg::BIT_DATA] && !wr_status
			|=> mem_fault_status_byte[mfsf_pkg::BIT_DATA])
		else $error("data flag dropped without a clear");

	a_unstack_sticky: assert property (
		mem_fault_status_byte[mfsf_pkg::BIT_UNSTACK] && !wr_status
			|=> mem_fault_status_byte[mfsf_pkg::BIT_UNSTACK])
		else $error("unstacking flag dropped without a clear");

	a_valid_clear: assert property (
		wr_status && wb_dat_i[mfsf_pkg::BIT_ADDR_VAL] && !core_ev.data_err
			|=> !mem_fault_status_byte[mfsf_pkg::BIT_ADDR_VAL])
		else $error("valid bit did not clear on a one");

	a_clear_one: assert property (
		wr_status && wb_dat_i[mfsf_pkg::BIT_STACK] && !core_ev.stack_err
			|=> !mem_fault_status_byte[mfsf_pkg::BIT_STACK])
		else $error("one-to-clear did not clear");

	a_write_zero_keeps: assert property (
		wr_status && !wb_dat_i[mfsf_pkg::BIT_UNSTACK]
			&& mem_fault_status_byte[mfsf_pkg::BIT_UNSTACK]
			|=> mem_fault_status_byte[mfsf_pkg::BIT_UNSTACK])
		else $error("writing zero cleared a flag");

	a_valid_needs_data: assert property (
		$rose(mem_fault_status_byte[mfsf_pkg::BIT_ADDR_VAL])
			|-> $past(core_ev.data_err))
		else $error("valid bit rose without an address capture");

	a_reserved_zero: assert property (
		(mem_fault_status_byte & ~mfsf_pkg::STATUS_MASK) == 8'h00)
		else $error("reserved status bit set");

	// Status read returns byte
	// Upper lanes are zero so reserved and unused bits read as zero
	a_status_read: assert property (
		req && !wb_we_i && wb_adr_i == mfsf_pkg::OFS_STATUS
			|=> wb_dat_o == {24'h00_0000, $past(mem_fault_status_byte)})
		else $error("status read returned a wrong word");

	// Single-cycle acknowledge
	a_ack_single: assert property (
		req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single-cycle answer");

	// Main scenarios worth seeing at least once
	c_data_fault: cover property (
		core_ev.data_err ##1 wr_status ##1 1'b1);
	c_set_and_clear: cover property (
		core_ev.unstack_err && wr_status && wb_dat_i[mfsf_pkg::BIT_UNSTACK]);
	c_xn_fetch: cover property (
		core_ev.fetch_issue && core_ev.fetch_xn && !core_ev.mpu_enable);
	c_status_read: cover property (
		req && !wb_we_i && mem_fault_status_byte != 8'h00);
	c_capture_race: cover property (
		core_ev.data_err && wr_faddr);

endmodule : mfsf_status

/* File: mfsf_status_tb.sv */
// Self-checking bench for the memory fault status byte.
// Assumes the core model turns one go pulse into one event.
`timescale 1ns/1ps
module mfsf_status_tb;
	logic        clk = 1'b0, sys_rst = 1'b1, go = 1'b0;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
	logic [7:0]  adr = 8'h00, st, est = 8'h00, f;
	logic [3:0]  sel = 4'hF;
	logic [1:0]  kind = 2'h0;
	logic [2:0]  lvl = 3'h0;
	logic [31:0] wdat = 32'h0, addr = 32'h0, rdat, dat_o, fa;
	logic [31:0] seed = 32'h0001_3ABF, efa = 32'h0;
	int          err_total = 0, num_checks = 0;
	mfsf_pkg::mfsf_core_ev_t   ev;
	mfsf_pkg::mfsf_core_resp_t rsp;

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	mfsf_status uut (
		.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .core_ev(ev), .core_resp(rsp),
		.mem_fault_status_byte(st), .mem_fault_address_reg(fa)
	);
	mfsf_core_model core (
		.go(go), .kind(kind), .addr(addr), .lvl(lvl), .ev(ev)
	);

	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction : xs

	// Flags one event should raise; fetch needs xn or enabled deny
	function automatic logic [7:0] flag_of(input logic [1:0] k,
		input logic [2:0] l);
		case (k)
			2'h0: return 8'h10;
			2'h1: return 8'h08;
			2'h2: return 8'h82;
			default: return (l[2] | (l[1] & l[0])) ? 8'h01 : 8'h00;
		endcase
	endfunction : flag_of

	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One classic cycle, entered and left on a rising edge
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 8);
		if (ack !== 1'b1) begin
			err_total++;
			tally_and_finish();
		end
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : bus

	// One core event, results checked one cycle later
	task automatic fire(input logic [1:0] k, input logic [31:0] a,
		input logic [2:0] l);
		go <= 1'b1;
		kind <= k;
		addr <= a;
		lvl <= l;
		@(posedge clk);
		go <= 1'b0;
		#1;
		f = flag_of(k, l);
		est = est | f;
		if (f[7])
			efa = a;
		chk("status", 32'(st), 32'(est));
		chk("faddr", fa, efa);
		chk("take", 32'(rsp.fault_take), 32'(f != 8'h00));
		if (k < 2'h2)
			chk("sp", 32'(rsp.adjust_sp), 32'(k == 2'h0));
		if (k < 2'h2)
			chk("save", 32'(rsp.save_frame), 32'(k == 2'h0));
		if (k < 2'h2)
			chk("pc0", 32'(rsp.pc_at_fault), 32'h0);
		if (k > 2'h1)
			chk("pc", 32'(rsp.pc_at_fault), 32'(f != 8'h00));
		@(posedge clk);
	endtask : fire

	// Reset, random events with one-to-clear writes, then corners
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		bus(1'b0, mfsf_pkg::OFS_STATUS, 32'h0);
		chk("reset", rdat, 32'h0);
		fire(2'h3, 32'h0000_1000, 3'h4);
		fire(2'h3, 32'h0000_2000, 3'h2);
		for (int i = 0; i < 60; i++) begin
			seed = xs(seed);
			fire(seed[1:0], xs(seed), seed[4:2]);
			if (seed[5]) begin
				bus(1'b1, mfsf_pkg::OFS_STATUS, {24'h0, seed[15:8]});
				est = est & ~seed[15:8];
				bus(1'b0, mfsf_pkg::OFS_STATUS, 32'h0);
				chk("st_rd", rdat, {24'h0, est});
			end
		end
		fire(2'h2, 32'hDEAD_BEEF, 3'h0);
		// Lane 0 disabled: the status write must not clear anything
		sel <= 4'hE;
		bus(1'b1, mfsf_pkg::OFS_STATUS, 32'h0000_00FF);
		sel <= 4'hF;
		chk("sel_off", 32'(st), 32'(est));
		// Escalated-fault handler drops the valid bit
		bus(1'b1, mfsf_pkg::OFS_STATUS, 32'h0000_0080);
		est = est & 8'h7F;
		chk("valid_clr", 32'(st), 32'(est));
		bus(1'b0, mfsf_pkg::OFS_FADDR, 32'h0);
		chk("faddr_rd", rdat, efa);
		sel <= 4'h3;
		bus(1'b1, mfsf_pkg::OFS_FADDR, 32'h1234_5678);
		sel <= 4'hF;
		efa = {efa[31:16], 16'h5678};
		bus(1'b0, mfsf_pkg::OFS_FADDR, 32'h0);
		chk("faddr_lane", rdat, efa);
		// Event and one-to-clear on the same edge: set wins
		fork
			fire(2'h1, 32'h0, 3'h0);
			bus(1'b1, mfsf_pkg::OFS_STATUS, 32'h0000_0008);
		join
		bus(1'b0, mfsf_pkg::OFS_STATUS, 32'h0);
		chk("set_wins", rdat, {24'h0, est});
		// Data capture beats a same-edge software write
		fork
			fire(2'h2, 32'h0BAD_F00D, 3'h0);
			bus(1'b1, mfsf_pkg::OFS_FADDR, 32'h5555_AAAA);
		join
		chk("faddr_race", fa, efa);
		// Second reset in mid-run
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		est = 8'h00;
		efa = 32'h0;
		@(posedge clk);
		chk("rst_st", 32'(st), 32'h0);
		chk("rst_fa", fa, 32'h0);
		chk("rst_rsp", 32'(rsp), 32'h0);
		bus(1'b1, 8'h08, 32'hFFFF_FFFF);
		bus(1'b0, 8'h08, 32'h0);
		chk("unmapped", rdat, 32'h0);
		chk("st_hold", 32'(st), 32'(est));
		tally_and_finish();
	end
endmodule : mfsf_status_tb
